/* File: rtl/tmr_regs_config.v */
// temperature monitor: serial register slave, configuration, scheduling, limit compare
`include "tmr_defines.vh"

// Function
// - five result registers, converter-written, host read-only
// - results at 0x00, 0x01/0x10, 0x30/0x33
// - bank bit aliases remote 2 onto remote 1
// - results read zero until first conversion
// - configuration 1 read 0x03, written 0x09
// - bit 7 masks alert; ignored in secondary mode
// - standby stops conversions; bus stays alive
// - bit 5 picks alert or secondary overtemperature
// - bit 2 selects extended range
// - bits 1/0 mask remote 1/2 alerts
// - lock bit freezes lockable registers until power-off
// - rate read 0x04, written 0x0a, resets 0x08
// - rate codes set interval; 1011 continuous
// - bit 7 disables averaging on slower rates
// - bits 5:4 choose measured channels
// - per-channel high/low/overtemp limits plus hysteresis
// - at or below low limit is out of limit
// - above overtemp or high limit pulls pins low
// - shared hysteresis, default ten degrees, governs overtemperature release
// - limits compared unconverted in current format
// - first written byte loads pointer; resets zero
// - extended range encodes with +64 offset
// - low byte read freezes high byte until read
module tmr_regs_config #(
  parameter [6:0] DEV_ADDR = 7'h4c,
  parameter [31:0] FAST_PERIOD_CYCLES = `TMR_FAST_PERIOD_CYC
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // serial bus
  input wire sclk,
  input wire sdata_in,
  output wire sdata_out,
  output wire sdata_oe_n,
  // overtemperature pin, open drain
  input wire overtemp_output_in,
  output wire overtemp_output_out,
  output wire overtemp_output_oe_n,
  // shared alert / secondary overtemperature pin, open drain
  input wire shared_pin_in,
  output wire shared_pin_out,
  output wire shared_pin_oe_n,
  // converter
  output reg conv_start,
  output reg [1:0] conv_channel,
  output reg conv_avg_enable,
  output reg conv_range_ext,
  input wire conv_done,
  input wire signed [11:0] conv_temp,
  // limit flags, bit per channel: local, remote 1, remote 2
  output wire [2:0] limit_high_flags,
  output wire [2:0] limit_low_flags
);

  // --------------------------------------------------------------------------
  // reset release and pin synchronisers
  // --------------------------------------------------------------------------
  reg [1:0] rst_sync;
  wire rst_n = rst_sync[1];
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  reg scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d} <= 6'h3f;
    end else begin
      scl_s1 <= sclk;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sdata_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end
  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;
  wire bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;

  // --------------------------------------------------------------------------
  // configuration state
  // --------------------------------------------------------------------------
  reg [7:0] cfg1, rate, cfg2;
  wire locked = cfg2[`TMR_C2_LOCK];
  wire standby = cfg1[`TMR_C1_STANDBY];
  wire bank = cfg1[`TMR_C1_BANK];
  wire range_ext = cfg1[`TMR_C1_RANGE];
  wire role_sec = cfg1[`TMR_C1_ROLE];
  wire [1:0] chan_sel = rate[`TMR_RT_CH_HI:`TMR_RT_CH_LO];
  wire [3:0] rate_code = rate[3:0];

  // --------------------------------------------------------------------------
  // serial slave
  // --------------------------------------------------------------------------
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_ADDR = 7'h02;
  localparam [6:0] S_AACK = 7'h04;
  localparam [6:0] S_WR = 7'h08;
  localparam [6:0] S_WACK = 7'h10;
  localparam [6:0] S_RD = 7'h20;
  localparam [6:0] S_RACK = 7'h40;

  reg [6:0] state;
  reg [2:0] bitcnt;
  reg [7:0] shreg, tx, ptr, wr_byte;
  reg byte_full, rw, first, sda_low, ack_ok, wr_pulse, rd_load;
  reg [7:0] rd_data;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      bitcnt <= 3'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      ptr <= `TMR_A_LOCAL;
      wr_byte <= 8'h00;
      byte_full <= 1'b0;
      rw <= 1'b0;
      first <= 1'b0;
      sda_low <= 1'b0;
      ack_ok <= 1'b0;
      wr_pulse <= 1'b0;
      rd_load <= 1'b0;
    end else begin
      wr_pulse <= 1'b0;
      rd_load <= 1'b0;
      if (bus_start) begin
        state <= S_ADDR;
        bitcnt <= 3'h0;
        byte_full <= 1'b0;
        first <= 1'b1;
        sda_low <= 1'b0;
      end else if (bus_stop) begin
        state <= S_IDLE;
        sda_low <= 1'b0;
      end else begin
        case (state)
          S_ADDR, S_WR: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s2};
              bitcnt <= bitcnt + 3'h1;
              byte_full <= (bitcnt == 3'h7);
            end else if (scl_fall && byte_full) begin
              byte_full <= 1'b0;
              if (state == S_ADDR) begin
                if (shreg[7:1] == DEV_ADDR) begin
                  sda_low <= 1'b1;
                  rw <= shreg[0];
                  state <= S_AACK;
                end else begin
                  state <= S_IDLE;
                end
              end else begin
                sda_low <= 1'b1;
                state <= S_WACK;
                first <= 1'b0;
                if (first) begin
                  ptr <= shreg;
                end else begin
                  wr_pulse <= 1'b1;
                  wr_byte <= shreg;
                end
              end
            end
          end
          S_AACK: begin
            if (scl_fall) begin
              bitcnt <= 3'h0;
              if (rw) begin
                tx <= rd_data;
                sda_low <= ~rd_data[7];
                rd_load <= 1'b1;
                state <= S_RD;
              end else begin
                sda_low <= 1'b0;
                state <= S_WR;
              end
            end
          end
          S_WACK: begin
            if (scl_fall) begin
              sda_low <= 1'b0;
              bitcnt <= 3'h0;
              state <= S_WR;
            end
          end
          S_RD: begin
            if (scl_fall) begin
              if (bitcnt == 3'h7) begin
                sda_low <= 1'b0;
                state <= S_RACK;
              end else begin
                tx <= {tx[6:0], 1'b0};
                sda_low <= ~tx[6];
                bitcnt <= bitcnt + 3'h1;
              end
            end
          end
          S_RACK: begin
            if (scl_rise) begin
              ack_ok <= ~sda_s2;
            end else if (scl_fall) begin
              bitcnt <= 3'h0;
              if (ack_ok) begin
                tx <= rd_data;
                sda_low <= ~rd_data[7];
                rd_load <= 1'b1;
                state <= S_RD;
              end else begin
                state <= S_IDLE;
              end
            end
          end
          S_IDLE: begin
            sda_low <= 1'b0;
          end
          default: begin
            state <= S_IDLE;
            sda_low <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sdata_out = 1'b0;
  assign sdata_oe_n = ~sda_low;

  // --------------------------------------------------------------------------
  // limit store address decode, remote 1 addresses follow the bank bit
  // --------------------------------------------------------------------------
  reg [3:0] lim_idx;
  reg lim_hit;
  always @* begin
    lim_hit = 1'b1;
    lim_idx = `TMR_I_HYST;
    case (ptr)
      `TMR_A_L_HIGH: lim_idx = `TMR_I_L_HIGH;
      `TMR_A_L_LOW: lim_idx = `TMR_I_L_LOW;
      `TMR_A_L_TH: lim_idx = `TMR_I_L_TH;
      `TMR_A_R1_HH: lim_idx = bank ? `TMR_I_R2_HH : `TMR_I_R1_HH;
      `TMR_A_R1_HL: lim_idx = bank ? `TMR_I_R2_HL : `TMR_I_R1_HL;
      `TMR_A_R1_LH: lim_idx = bank ? `TMR_I_R2_LH : `TMR_I_R1_LH;
      `TMR_A_R1_LL: lim_idx = bank ? `TMR_I_R2_LL : `TMR_I_R1_LL;
      `TMR_A_R1_TH: lim_idx = bank ? `TMR_I_R2_TH : `TMR_I_R1_TH;
      `TMR_A_R2_HH: lim_idx = `TMR_I_R2_HH;
      `TMR_A_R2_HL: lim_idx = `TMR_I_R2_HL;
      `TMR_A_R2_LH: lim_idx = `TMR_I_R2_LH;
      `TMR_A_R2_LL: lim_idx = `TMR_I_R2_LL;
      `TMR_A_R2_TH: lim_idx = `TMR_I_R2_TH;
      `TMR_A_HYST: lim_idx = `TMR_I_HYST;
      default: lim_hit = 1'b0;
    endcase
  end

  wire [7:0] lim_rdata;
  wire [8*`TMR_LIM_WORDS-1:0] lim;
  tmr_limit_regs u_limits (
    .clk(clk),
    .rst_n(rst_n),
    .we(wr_pulse & lim_hit & ~locked),
    .waddr(lim_idx),
    .wdata(wr_byte),
    .raddr(lim_idx),
    .rdata(lim_rdata),
    .words(lim)
  );

  // --------------------------------------------------------------------------
  // configuration writes; result registers have no write path
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg1 <= `TMR_CFG1_RST;
      rate <= `TMR_RATE_RST;
      cfg2 <= `TMR_CFG2_RST;
    end else if (wr_pulse) begin
      if (ptr == `TMR_A_CFG1_WR && !locked) begin
        cfg1 <= wr_byte;
      end
      // bit 6 is cleared from every host write, so it is held at zero
      if (ptr == `TMR_A_RATE_WR && !locked) begin
        rate <= wr_byte & ~(8'h01 << `TMR_RT_RSV);
      end
      // lock only ever sets; nothing but power-on clears it
      if (ptr == `TMR_A_CFG2 && wr_byte[`TMR_C2_LOCK]) begin
        cfg2 <= cfg2 | (8'h01 << `TMR_C2_LOCK);
      end
    end
  end

  // --------------------------------------------------------------------------
  // result formatting
  // --------------------------------------------------------------------------
  wire signed [12:0] t_wide = {conv_temp[11], conv_temp} +
                              (range_ext ? `TMR_EXT_OFFSET : 13'sd0);
  wire signed [12:0] t_max = range_ext ? `TMR_EXT_MAX : `TMR_BIN_MAX;
  wire [9:0] new_res = (t_wide < 13'sd0) ? 10'h000 :
                       (t_wide > t_max) ? t_max[9:0] : t_wide[9:0];

  // --------------------------------------------------------------------------
  // per-channel results, freeze and compare
  // --------------------------------------------------------------------------
  wire [29:0] res_flat;
  wire [23:0] hi_vis;
  wire [2:0] overtemp_output_act, secondary_overtemp_output_act;
  wire [7:0] hyst = lim[8*`TMR_I_HYST +: 8];
  wire [1:0] lo_ch = bank ? 2'd2 : 2'd1;

  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_ch
      localparam HH = (i == 0) ? `TMR_I_L_HIGH : (i == 1) ? `TMR_I_R1_HH : `TMR_I_R2_HH;
      localparam HL = (i == 2) ? `TMR_I_R2_HL : `TMR_I_R1_HL;
      localparam LH = (i == 0) ? `TMR_I_L_LOW : (i == 1) ? `TMR_I_R1_LH : `TMR_I_R2_LH;
      localparam LL = (i == 2) ? `TMR_I_R2_LL : `TMR_I_R1_LL;
      localparam TH = (i == 0) ? `TMR_I_L_TH : (i == 1) ? `TMR_I_R1_TH : `TMR_I_R2_TH;
      wire [7:0] hh = lim[8*HH +: 8];
      wire [7:0] th = lim[8*TH +: 8];
      // local has no fractional limit byte
      wire [9:0] hi10 = {hh, (i == 0) ? 2'b00 : lim[8*HL+6 +: 2]};
      wire [9:0] lo10 = {lim[8*LH +: 8], (i == 0) ? 2'b00 : lim[8*LL+6 +: 2]};
      wire [7:0] th_rel = (th > hyst) ? th - hyst : 8'h00;
      wire [7:0] hh_rel = (hh > hyst) ? hh - hyst : 8'h00;
      wire upd = conv_done && conv_channel == i && !standby;
      reg [9:0] res;
      reg [7:0] hold;
      reg frozen, f_high, f_low, t_act, t2_act;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          res <= 10'h000;
          hold <= 8'h00;
          frozen <= 1'b0;
          f_high <= 1'b0;
          f_low <= 1'b0;
          t_act <= 1'b0;
          t2_act <= 1'b0;
        end else begin
          if (upd) begin
            res <= new_res;
            f_high <= new_res > hi10;
            f_low <= new_res <= lo10;
            if (new_res[9:2] > th) begin
              t_act <= 1'b1;
            end else if (new_res[9:2] < th_rel) begin
              t_act <= 1'b0;
            end
            if (new_res[9:2] > hh) begin
              t2_act <= 1'b1;
            end else if (new_res[9:2] < hh_rel) begin
              t2_act <= 1'b0;
            end
          end
          if (i != 0 && rd_load) begin
            if ((ptr == `TMR_A_R1_LO && lo_ch == i) || (i == 2 && ptr == `TMR_A_R2_LO)) begin
              frozen <= 1'b1;
              hold <= res[9:2];
            end else if ((ptr == `TMR_A_R1_HI && lo_ch == i) ||
                         (i == 2 && ptr == `TMR_A_R2_HI)) begin
              frozen <= 1'b0;
            end
          end
        end
      end
      assign res_flat[10*i +: 10] = res;
      assign hi_vis[8*i +: 8] = frozen ? hold : res[9:2];
      assign limit_high_flags[i] = f_high;
      assign limit_low_flags[i] = f_low;
      assign overtemp_output_act[i] = t_act;
      assign secondary_overtemp_output_act[i] = t2_act;
    end
  endgenerate

  // --------------------------------------------------------------------------
  // host read mux
  // --------------------------------------------------------------------------
  always @* begin
    case (ptr)
      `TMR_A_LOCAL: rd_data = hi_vis[7:0];
      `TMR_A_R1_HI: rd_data = bank ? hi_vis[23:16] : hi_vis[15:8];
      `TMR_A_R1_LO: rd_data = {bank ? res_flat[21:20] : res_flat[11:10], 6'h00};
      `TMR_A_R2_HI: rd_data = hi_vis[23:16];
      `TMR_A_R2_LO: rd_data = {res_flat[21:20], 6'h00};
      `TMR_A_CFG1_RD: rd_data = cfg1;
      `TMR_A_RATE_RD: rd_data = rate;
      `TMR_A_CFG2: rd_data = cfg2;
      default: rd_data = lim_hit ? lim_rdata : 8'h00;
    endcase
  end

  // --------------------------------------------------------------------------
  // conversion scheduling
  // --------------------------------------------------------------------------
  reg [31:0] tick_cnt;
  reg busy;
  wire cont = rate_code >= `TMR_RATE_CONT;
  // interval doubles for each step below the fastest code
  wire [31:0] period = FAST_PERIOD_CYCLES << (`TMR_RATE_FASTEST - rate_code);
  wire tick = cont ? ~busy : (tick_cnt + 32'h1 >= period);
  wire [1:0] first_ch = (chan_sel == 2'b00) ? 2'd0 : chan_sel - 2'd1;
  wire more = conv_done && chan_sel == 2'b00 && conv_channel != 2'd2;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 32'h0;
      busy <= 1'b0;
      conv_start <= 1'b0;
      conv_channel <= 2'd0;
      conv_avg_enable <= 1'b0;
      conv_range_ext <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      conv_range_ext <= range_ext;
      // three fastest codes and continuous never average
      conv_avg_enable <= ~rate[`TMR_RT_AVG_DIS] & (rate_code < `TMR_RATE_NOAVG);
      if (standby) begin
        tick_cnt <= 32'h0;
        busy <= 1'b0;
      end else begin
        tick_cnt <= (tick || cont) ? 32'h0 : tick_cnt + 32'h1;
        if (more) begin
          conv_channel <= conv_channel + 2'd1;
          conv_start <= 1'b1;
        end else if (conv_done) begin
          busy <= 1'b0;
        end else if (tick && !busy) begin
          conv_channel <= first_ch;
          conv_start <= 1'b1;
          busy <= 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // output pins; standby leaves both released
  // --------------------------------------------------------------------------
  wire alert_cond = limit_high_flags[0] | limit_low_flags[0] |
                    ((limit_high_flags[1] | limit_low_flags[1]) & ~cfg1[`TMR_C1_FIRST_REMOTE_ALERT_MASK]) |
                    ((limit_high_flags[2] | limit_low_flags[2]) & ~cfg1[`TMR_C1_SECOND_REMOTE_ALERT_MASK]);
  reg overtemp_output_low, shared_low;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overtemp_output_low <= 1'b0;
      shared_low <= 1'b0;
    end else begin
      overtemp_output_low <= ~standby & (|overtemp_output_act);
      if (role_sec) begin
        shared_low <= ~standby & (|secondary_overtemp_output_act);
      end else begin
        shared_low <= ~standby & ~cfg1[`TMR_C1_MASK_ALL] & alert_cond;
      end
    end
  end

  assign overtemp_output_out = 1'b0;
  assign overtemp_output_oe_n = ~overtemp_output_low;
  assign shared_pin_out = 1'b0;
  assign shared_pin_oe_n = ~shared_low;

endmodule

/* File: rtl/tmr_defines.vh */
// register map, field positions, reset values and timing counts for the monitor
`ifndef TMR_DEFINES_VH
`define TMR_DEFINES_VH

// --------------------------------------------------------------------------
// register offsets
// --------------------------------------------------------------------------
`define TMR_A_LOCAL      8'h00
`define TMR_A_R1_HI      8'h01
`define TMR_A_CFG1_RD    8'h03
`define TMR_A_RATE_RD    8'h04
`define TMR_A_CFG1_WR    8'h09
`define TMR_A_RATE_WR    8'h0a
`define TMR_A_R1_LO      8'h10
`define TMR_A_CFG2       8'h24
`define TMR_A_R2_HI      8'h30
`define TMR_A_R2_LO      8'h33
`define TMR_A_L_HIGH     8'h05
`define TMR_A_L_LOW      8'h06
`define TMR_A_R1_HH      8'h07
`define TMR_A_R1_LH      8'h08
`define TMR_A_R1_HL      8'h13
`define TMR_A_R1_LL      8'h14
`define TMR_A_R1_TH      8'h19
`define TMR_A_L_TH       8'h20
`define TMR_A_HYST       8'h21
`define TMR_A_R2_HH      8'h36
`define TMR_A_R2_HL      8'h37
`define TMR_A_R2_LH      8'h38
`define TMR_A_R2_LL      8'h39
`define TMR_A_R2_TH      8'h3a

// --------------------------------------------------------------------------
// limit store entry indices
// --------------------------------------------------------------------------
`define TMR_I_L_HIGH     4'h0
`define TMR_I_L_LOW      4'h1
`define TMR_I_L_TH       4'h2
`define TMR_I_R1_HH      4'h3
`define TMR_I_R1_HL      4'h4
`define TMR_I_R1_LH      4'h5
`define TMR_I_R1_LL      4'h6
`define TMR_I_R1_TH      4'h7
`define TMR_I_R2_HH      4'h8
`define TMR_I_R2_HL      4'h9
`define TMR_I_R2_LH      4'ha
`define TMR_I_R2_LL      4'hb
`define TMR_I_R2_TH      4'hc
`define TMR_I_HYST       4'hd
`define TMR_LIM_WORDS    14

// --------------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------------
`define TMR_C1_MASK_ALL  7
`define TMR_C1_STANDBY   6
`define TMR_C1_ROLE      5
`define TMR_C1_BANK      3
`define TMR_C1_RANGE     2
`define TMR_C1_FIRST_REMOTE_ALERT_MASK   1
`define TMR_C1_SECOND_REMOTE_ALERT_MASK   0
`define TMR_C2_LOCK      7
`define TMR_RT_AVG_DIS   7
`define TMR_RT_RSV       6
`define TMR_RT_CH_HI     5
`define TMR_RT_CH_LO     4

// --------------------------------------------------------------------------
// reset values and codes
// --------------------------------------------------------------------------
`define TMR_CFG1_RST     8'h00
`define TMR_CFG2_RST     8'h00
`define TMR_RATE_RST     8'h08
`define TMR_HIGH_RST     8'h55
`define TMR_LOW_RST      8'h00
`define TMR_TH_RST       8'h55
`define TMR_HYST_RST     8'h0a
`define TMR_RATE_FASTEST 4'ha
`define TMR_RATE_CONT    4'hb
`define TMR_RATE_NOAVG   4'h8
`define TMR_EXT_OFFSET   13'sd256
`define TMR_BIN_MAX      13'sd511
`define TMR_EXT_MAX      13'sd1023

// --------------------------------------------------------------------------
// timing
// --------------------------------------------------------------------------
`define TMR_CLK_PERIOD_NS  25
`define TMR_FAST_PERIOD_NS 15500000
`define TMR_FAST_PERIOD_CYC (`TMR_FAST_PERIOD_NS / `TMR_CLK_PERIOD_NS)

`endif

/* File: rtl/tmr_limit_regs.v */
// limit and hysteresis store with registered host read port and flat compare view
`include "tmr_defines.vh"

module tmr_limit_regs (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // host write
  input wire we,
  input wire [3:0] waddr,
  input wire [7:0] wdata,
  // host read
  input wire [3:0] raddr,
  output reg [7:0] rdata,
  // compare view
  output wire [8*`TMR_LIM_WORDS-1:0] words
);

  genvar i;
  generate
    for (i = 0; i < `TMR_LIM_WORDS; i = i + 1) begin : g_word
      // pick each entry's power-on value by its role
      localparam [7:0] RST = (i == `TMR_I_HYST) ? `TMR_HYST_RST :
        (i == `TMR_I_L_TH || i == `TMR_I_R1_TH || i == `TMR_I_R2_TH) ? `TMR_TH_RST :
        (i == `TMR_I_L_HIGH || i == `TMR_I_R1_HH || i == `TMR_I_R2_HH) ? `TMR_HIGH_RST :
        `TMR_LOW_RST;
      reg [7:0] word;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          word <= RST;
        end else if (we && waddr == i) begin
          word <= wdata;
        end
      end
      assign words[8*i +: 8] = word;
    end
  endgenerate

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (raddr < `TMR_LIM_WORDS) begin
      rdata <= words[8*raddr +: 8];
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

/* File: testbench/tmr_regs_config_chk.sv */
// checker for the temperature monitor register block
module tmr_regs_config_chk (
  // clock and reset
  input wire clk,
  input wire resetn,
  // converter and flags
  input wire conv_start,
  input wire [1:0] conv_channel,
  input wire conv_done,
  input wire [2:0] limit_high_flags,
  input wire [2:0] limit_low_flags,
  // pin
  input wire overtemp_output_out
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence s_pulse;
    conv_start ##1 (!conv_start || $past(conv_done));
  endsequence
  a_start_one_cycle: assert property (conv_start |-> s_pulse)
    else $error("start repeated without result");
  a_chan_with_start: assert property ($changed(conv_channel) |-> conv_start)
    else $error("channel moved without start");
  a_chan_legal: assert property (conv_start |-> conv_channel != 2'd3)
    else $error("illegal channel");
  a_high_hold: assert property (!conv_done |=> $stable(limit_high_flags))
    else $error("high flags moved without result");
  a_low_hold: assert property (!conv_done |=> $stable(limit_low_flags))
    else $error("low flags moved without result");
  a_high_own_chan: assert property (conv_done |=> ((limit_high_flags ^
    $past(limit_high_flags)) & ~(3'd1 << $past(conv_channel))) == 3'd0)
    else $error("high flag of other channel moved");
  a_low_own_chan: assert property (conv_done |=> ((limit_low_flags ^
    $past(limit_low_flags)) & ~(3'd1 << $past(conv_channel))) == 3'd0)
    else $error("low flag of other channel moved");
  a_pin_drives_low: assert property (overtemp_output_out == 1'b0)
    else $error("open drain pin drives high");
endmodule
bind tmr_regs_config tmr_regs_config_chk tmr_regs_config_chk_inst (.clk(clk), .resetn(resetn),
  .conv_start(conv_start), .conv_channel(conv_channel), .conv_done(conv_done),
  .limit_high_flags(limit_high_flags), .limit_low_flags(limit_low_flags),
  .overtemp_output_out(overtemp_output_out));

/* File: testbench/tmr_host.sv */
// serial bus host model for the monitor's two-wire port
module tmr_host (
  // device side of the data pin
  input wire dev_out,
  input wire dev_oe_n,
  // bus
  output logic scl,
  output wire sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hold_low = 1'b0;
  // pull-up: a released line reads high
  assign sda = !(hold_low || (!dev_oe_n && !dev_out));
  initial scl = 1'b1;
  task automatic bit_io(input logic b, output logic r);
    hold_low = !b;
    #50 scl = 1'b1;
    #50 r = sda;
    #50 scl = 1'b0;
    #50;
  endtask
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(1'b1, a);
  endtask
  task automatic start_c;
    hold_low = 1'b0;
    scl = 1'b1;
    #100 hold_low = 1'b1;
    #100 scl = 1'b0;
    #50;
  endtask
  task automatic stop_c;
    hold_low = 1'b1;
    #50 scl = 1'b1;
    #50 hold_low = 1'b0;
    #100;
  endtask
  task automatic set_ptr(input logic [7:0] p);
    logic [7:0] x;
    start_c;
    byte_io(8'h98, x);
    byte_io(p, x);
  endtask
  task automatic reg_write(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] x;
    set_ptr(p);
    byte_io(d, x);
    stop_c;
  endtask
  task automatic reg_read(input logic [7:0] p, output logic [7:0] d);
    logic [7:0] x;
    set_ptr(p);
    stop_c;
    start_c;
    byte_io(8'h99, x);
    byte_io(8'hff, d);
    stop_c;
  endtask
endmodule

/* File: testbench/temp_monitor_regs_config_test.sv */
// self-checking bench for the temperature monitor register block
module temp_monitor_regs_config_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic conv_done = 1'b0;
  logic conv_on = 1'b0;
  logic signed [11:0] conv_temp = 12'sd0;
  logic signed [11:0] temps [3];
  logic [7:0] ra [5] = '{8'h00, 8'h01, 8'h10, 8'h30, 8'h33};
  wire scl, sda, sd_out, sd_oe_n, ot_out, ot_oe_n, sp_out, sp_oe_n, start, avg, rng_ext;
  wire [1:0] chan;
  wire [2:0] hi_f, lo_f;
  int seed = 32'hea1035d5;
  int fails = 0;
  int checks_done = 0;
  logic [7:0] d;
  logic [9:0] v;
  always #12.5 clk = !clk;
  tmr_host tmr_host_inst (.dev_out(sd_out), .dev_oe_n(sd_oe_n), .scl(scl), .sda(sda));
  tmr_regs_config #(.FAST_PERIOD_CYCLES(32'd8)) tmr_regs_config_inst (.clk(clk),
    .resetn(resetn), .sclk(scl), .sdata_in(sda), .sdata_out(sd_out), .sdata_oe_n(sd_oe_n),
    .overtemp_output_in(ot_oe_n | ot_out), .overtemp_output_out(ot_out),
    .overtemp_output_oe_n(ot_oe_n), .shared_pin_in(sp_oe_n | sp_out), .shared_pin_out(sp_out),
    .shared_pin_oe_n(sp_oe_n), .conv_start(start), .conv_channel(chan), .conv_avg_enable(avg),
    .conv_range_ext(rng_ext), .conv_done(conv_done), .conv_temp(conv_temp),
    .limit_high_flags(hi_f), .limit_low_flags(lo_f));
  // converter answers 1 ns after the edge that raises each start, so done is sampled on the edge after that start
  always @(posedge clk) begin
    #1 conv_done = start;
    conv_temp = conv_on ? temps[chan] : 12'sd0;
  end
  function automatic logic [9:0] exp_v(input logic signed [11:0] t, input logic ext);
    int x;
    x = t + (ext ? 256 : 0);
    x = x < 0 ? 0 : (x > (ext ? 1023 : 511) ? (ext ? 1023 : 511) : x);
    return x[9:0];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    tmr_host_inst.reg_read(a, d);
    chk(d, exp);
  endtask
  task automatic stop_test;
    $display("fails %0d checks %0d", fails, checks_done);
    if (fails == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    logic [7:0] r;
    int n;
    temps[0] = -12'sd40;
    temps[1] = 12'sh100 | (12'($random(seed)) & 12'sh4f);
    temps[2] = 12'sh100 | (12'($random(seed)) & 12'sh4f);
    repeat (8) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (4) @(posedge clk);
    foreach (ra[i]) rd(ra[i], 8'h00);
    rd(8'h03, 8'h00);
    rd(8'h04, 8'h08);
    tmr_host_inst.reg_write(8'h00, 8'hff);
    rd(8'h00, 8'h00);
    conv_on = 1'b1;
    repeat (200) @(posedge clk);
    v = exp_v(temps[1], 1'b0);
    rd(8'h10, {v[1:0], 6'h00});
    rd(8'h01, v[9:2]);
    v = exp_v(temps[2], 1'b0);
    rd(8'h33, {v[1:0], 6'h00});
    rd(8'h30, v[9:2]);
    rd(8'h00, 8'h00);
    tmr_host_inst.reg_write(8'h07, 8'h3f);
    tmr_host_inst.reg_write(8'h19, 8'h3f);
    repeat (100) @(posedge clk);
    chk({5'h0, hi_f}, 8'h02);
    chk({5'h0, lo_f}, 8'h01);
    chk({7'h0, ot_oe_n}, 8'h00);
    chk({7'h0, sp_oe_n}, 8'h00);
    rd(8'h07, 8'h3f);
    tmr_host_inst.reg_write(8'h09, 8'h08);
    rd(8'h01, v[9:2]);
    rd(8'h03, 8'h08);
    tmr_host_inst.reg_write(8'h09, 8'h04);
    repeat (200) @(posedge clk);
    v = exp_v(temps[0], 1'b1);
    rd(8'h00, v[9:2]);
    chk({7'h0, rng_ext}, 8'h01);
    for (int m = 0; m < 4; m++) begin
      r = {1'($random(seed)), 1'b0, 2'(m), 2'b10, 2'($random(seed))};
      tmr_host_inst.reg_write(8'h0a, r);
      rd(8'h04, r);
      n = 0;
      do begin
        @(posedge clk);
        #2;
        n++;
      end while (start !== 1'b1 && n < 2000);
      chk({7'h0, start}, 8'h01);
      if (m > 0) chk({6'h0, chan}, 8'(m - 1));
      chk({7'h0, avg}, 8'h00);
    end
    tmr_host_inst.reg_write(8'h09, 8'h40);
    repeat (10) @(posedge clk);
    n = 0;
    repeat (300) begin
      @(posedge clk);
      #2;
      n += start;
    end
    chk(8'(n), 8'h00);
    chk({7'h0, ot_oe_n}, 8'h01);
    tmr_host_inst.reg_write(8'h24, 8'h80);
    tmr_host_inst.reg_write(8'h09, 8'h00);
    rd(8'h03, 8'h40);
    rd(8'h24, 8'h80);
    stop_test;
  end
  initial begin
    #1ms;
    fails++;
    stop_test;
  end
endmodule
